//--- include/sgd_regs.svh
`ifndef SGD_REGS_SVH
`define SGD_REGS_SVH

// Register offsets as seen on the card register port
`define SGD_MAIN_CUR_ADDR 8'h00
`define SGD_MAIN_NXT_ADDR 8'h04
`define SGD_MAIN_CUR_CC 8'h08
`define SGD_MAIN_NXT_CC 8'h0c
`define SGD_LIST_CUR_ADDR 8'h10
`define SGD_LIST_NXT_ADDR 8'h14
`define SGD_LIST_CUR_CC 8'h18
`define SGD_LIST_NXT_CC 8'h1c
`define SGD_FLASH_ADDR 8'h80
`define SGD_FLASH_DATA 8'h84
`define SGD_IRQ_CFG 8'hc4
`define SGD_IRQ_STATUS 8'hc8
`define SGD_USER_DATA 8'hcc

// Bit positions in the list next count/control register; SGD_B_ENTRY_IRQ is in the entry's second word
`define SGD_B_RDY_IRQ_EN 31
`define SGD_B_DONE 30
`define SGD_B_START 29
`define SGD_B_PAGE_IRQ_EN 28
`define SGD_B_LIST_IRQ_EN 27
`define SGD_B_ABORT 26
`define SGD_B_DIR_RD 25
`define SGD_B_BURST 24
`define SGD_B_MAIN_IDLE 23
`define SGD_B_MAIN_EMPTY 22
`define SGD_B_PAGE_INT 18
`define SGD_B_ENTRY_IRQ 16
// Bit positions in the interrupt registers
`define SGD_B_DMA_INT 12
`define SGD_B_GLOBAL_IRQ_EN 15

// List entry layout and address steps
`define SGD_ENTRY_BYTES 16'h0008
`define SGD_ENTRY_STRIDE 32'h0000_0008
`define SGD_ENTRY_CC_OFS 32'h0000_0004
`define SGD_WORD_STEP 32'h0000_0004
`define SGD_ENTRY_ALIGN_MASK 16'h0007

// Host side: command address bit that selects host memory
`define SGD_HOST_MEM_BIT 8
`define SGD_MEM_WORDS 64

`endif

//--- include/sgd_pkg.sv
package sgd_pkg;

  // Entry fetch sequencer, one-hot
  typedef enum logic [4:0] {
    SGD_F_IDLE = 5'b00001,
    SGD_F_REQA = 5'b00010,
    SGD_F_GETA = 5'b00100,
    SGD_F_REQC = 5'b01000,
    SGD_F_GETC = 5'b10000
  } sgd_fetch_t;

  // Software steered control bits of the list next count/control
  typedef struct packed {
    logic rdy_irq_en;
    logic page_irq_en;
    logic list_irq_en;
    logic dir_rd;
    logic burst;
  } sgd_ctl_t;

  typedef struct packed {
    sgd_fetch_t fetch;
    logic [31:0] m_cur_addr;
    logic [31:0] m_nxt_addr;
    logic [15:0] m_cur_cnt;
    logic [15:0] m_nxt_cnt;
    logic m_cur_pg;
    logic m_nxt_pg;
    logic m_nxt_full;
    logic m_active;
    logic [31:0] l_cur_addr;
    logic [31:0] l_nxt_addr;
    logic [15:0] l_cur_cnt;
    logic [15:0] l_nxt_cnt;
    sgd_ctl_t ctl;
    logic l_nxt_valid;
    logic l_start;
    logic l_done;
    logic l_active;
    logic rsp_main;
    logic [31:0] ent_addr;
    logic dma_int;
    logic pg_int;
    logic [31:0] flash_addr;
    logic [7:0] flash_data;
    logic [31:0] irq_cfg;
    logic [31:0] user_data;
    logic [31:0] rdata;
    logic ui_out_valid;
    logic [31:0] ui_out_data;
  } sgd_dev_st_t;

  typedef struct packed {
    logic [31:0] mem_rd;
    logic [31:0] cmd_mem;
    logic sel_mem;
    logic cc_rd;
    logic open;
    logic armed;
  } sgd_host_st_t;

endpackage

//--- include/sgd_link_if.sv
interface sgd_link_if;
  // Register port, driven by the host except reg_rdata, which the card drives
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  // Bus-master memory port, driven by the card except mem_rdata, which the host drives
  logic mem_req;
  logic mem_we;
  logic [31:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic irq;

  modport dev (
    input reg_addr, reg_wdata, reg_wr, reg_rd, mem_rdata,
    output reg_rdata, mem_req, mem_we, mem_addr, mem_wdata, irq
  );
  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd, mem_rdata,
    input reg_rdata, mem_req, mem_we, mem_addr, mem_wdata, irq
  );
endinterface

//--- hw/sgd_device.sv
// Summary of operation
// RULE1: list entries are eight bytes each
// RULE2: entry first word is page address
// RULE3: second word: count low, control high
// RULE4: bit16 plus enable raises page interrupt
// RULE5: fetch entries in order into next
// RULE6: main DMA registers read-only to host
// RULE7: software writes address, then count with start
// RULE8: software reloads only after start bit reads
// RULE9: main next address copies to current
// RULE10: current address keeps last used value; code leaves it one word past the last word moved
// RULE11: main next count copies to current
// RULE12: low count bits show words remaining
// RULE13: main current high bits mirror list
// RULE14: main next high bits mirror list
// RULE15: list current loads when valid, done
// RULE16: list next address host read/write
// RULE17: software leaves flash registers alone
// RULE18: start bit pending reads zero, locked
// RULE19: abort stops, cancels, clears done/start
// RULE20: done bit zero while list runs
// RULE21: done and ready enables raise interrupt
// RULE22: fetch by memory read, length minus eight
// RULE23: load next when empty, chain immediately
`include "sgd_regs.svh"

module sgd_device
  import sgd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  sgd_link_if.dev lnk,
  input wire logic ui_ready,
  input wire logic [31:0] ui_in_data,
  output logic ui_out_valid,
  output logic [31:0] ui_out_data,
  output logic list_busy
);

  sgd_dev_st_t s;
  sgd_dev_st_t n;
  logic main_go;
  logic main_end;
  logic abort_now;

  // Upper half shared by all count/control views
  function automatic logic [15:0] ctl_hi(input sgd_dev_st_t v);
    logic [15:0] h;
    h = 16'h0000;
    h[`SGD_B_RDY_IRQ_EN - 16] = v.ctl.rdy_irq_en;
    h[`SGD_B_DONE - 16] = v.l_done;
    h[`SGD_B_START - 16] = v.l_start;
    h[`SGD_B_PAGE_IRQ_EN - 16] = v.ctl.page_irq_en;
    h[`SGD_B_LIST_IRQ_EN - 16] = v.ctl.list_irq_en;
    h[`SGD_B_DIR_RD - 16] = v.ctl.dir_rd;
    h[`SGD_B_BURST - 16] = v.ctl.burst;
    h[`SGD_B_MAIN_IDLE - 16] = ~v.m_active;
    h[`SGD_B_MAIN_EMPTY - 16] = ~v.m_nxt_full;
    h[`SGD_B_PAGE_INT - 16] = v.pg_int;
    return h;
  endfunction

  // Main engine moves one word per cycle while the user side is ready
  assign main_go = s.m_active && (s.m_cur_cnt != 16'h0000) && ui_ready
    && !abort_now;
  assign main_end = s.m_active && (s.m_cur_cnt == 16'h0000);
  assign abort_now = lnk.reg_wr && (lnk.reg_addr == `SGD_LIST_NXT_CC)
    && lnk.reg_wdata[`SGD_B_ABORT];

  // Next state; order matters: software clears first, hardware sets win, abort clears last
  always_comb
  begin
    n = s;
    n.ui_out_valid = 1'b0;
    n.rsp_main = 1'b0;
    lnk.mem_req = 1'b0;
    lnk.mem_we = 1'b0;
    lnk.mem_addr = s.m_cur_addr;
    lnk.mem_wdata = ui_in_data;

    // Register writes
    if (lnk.reg_wr)
    begin
      case (lnk.reg_addr)
        `SGD_LIST_NXT_ADDR:
        begin
          // RULE16: host writable next address
          // RULE18: locked while pending
          if (!s.l_nxt_valid)
            n.l_nxt_addr = lnk.reg_wdata;
        end
        `SGD_LIST_NXT_CC:
        begin
          // Any write here acknowledges pending interrupts
          n.dma_int = 1'b0;
          n.pg_int = 1'b0;
          // RULE18: locked while pending
          if (!s.l_nxt_valid)
          begin
            n.ctl.rdy_irq_en = lnk.reg_wdata[`SGD_B_RDY_IRQ_EN];
            n.ctl.page_irq_en = lnk.reg_wdata[`SGD_B_PAGE_IRQ_EN];
            n.ctl.list_irq_en = lnk.reg_wdata[`SGD_B_LIST_IRQ_EN];
            n.ctl.dir_rd = lnk.reg_wdata[`SGD_B_DIR_RD];
            n.ctl.burst = lnk.reg_wdata[`SGD_B_BURST];
            n.l_nxt_cnt = lnk.reg_wdata[15:0];
            // RULE18: start marks next valid, bit reads zero
            if (lnk.reg_wdata[`SGD_B_START])
            begin
              n.l_nxt_valid = 1'b1;
              n.l_start = 1'b0;
            end
          end
        end
        // Flash window is plain storage for the update utility
        `SGD_FLASH_ADDR: n.flash_addr = lnk.reg_wdata;
        `SGD_FLASH_DATA: n.flash_data = lnk.reg_wdata[7:0];
        `SGD_IRQ_CFG: n.irq_cfg = lnk.reg_wdata;
        `SGD_USER_DATA: n.user_data = lnk.reg_wdata;
        // RULE6: main registers ignore host writes
        default: n.user_data = s.user_data;
      endcase
    end

    // RULE12: count down per word moved
    if (main_go)
    begin
      lnk.mem_req = 1'b1;
      lnk.mem_we = ~s.ctl.dir_rd;
      // RULE10: current address tracks the word in use
      n.m_cur_addr = s.m_cur_addr + `SGD_WORD_STEP;
      n.m_cur_cnt = s.m_cur_cnt - 16'h0001;
      n.rsp_main = s.ctl.dir_rd;
    end
    // Read data from memory arrives one cycle after the request
    if (s.rsp_main)
    begin
      n.ui_out_valid = 1'b1;
      n.ui_out_data = lnk.mem_rdata;
    end

    // Page end; address stays one word past the last word moved
    if (main_end)
    begin
      n.m_active = 1'b0;
      // RULE4: marked page raises page interrupt
      if (s.m_cur_pg && s.ctl.page_irq_en)
        n.pg_int = 1'b1;
    end
    // RULE23: chain to next page in the cycle the old one ends
    if ((!s.m_active || main_end) && s.m_nxt_full)
    begin
      // RULE9: next address to current
      n.m_cur_addr = s.m_nxt_addr;
      // RULE11: next count to current
      n.m_cur_cnt = s.m_nxt_cnt;
      n.m_cur_pg = s.m_nxt_pg;
      n.m_active = 1'b1;
      n.m_nxt_full = 1'b0;
    end

    // RULE5: entries fetched in order; memory port yields to data words
    case (s.fetch)
      SGD_F_IDLE:
      begin
        // RULE23: fetch only into an empty next slot
        if (s.l_active && (s.l_cur_cnt != 16'h0000) && !s.m_nxt_full)
          n.fetch = SGD_F_REQA;
      end
      SGD_F_REQA:
      begin
        // RULE22: bus-master read of the entry
        if (!main_go)
        begin
          lnk.mem_req = 1'b1;
          lnk.mem_addr = s.l_cur_addr;
          n.fetch = SGD_F_GETA;
        end
      end
      SGD_F_GETA:
      begin
        // RULE2: first word is the page address
        n.ent_addr = lnk.mem_rdata;
        n.fetch = SGD_F_REQC;
      end
      SGD_F_REQC:
      begin
        if (!main_go)
        begin
          lnk.mem_req = 1'b1;
          lnk.mem_addr = s.l_cur_addr + `SGD_ENTRY_CC_OFS;
          n.fetch = SGD_F_GETC;
        end
      end
      SGD_F_GETC:
      begin
        n.m_nxt_addr = s.ent_addr;
        // RULE3: count low half, control high half
        n.m_nxt_cnt = lnk.mem_rdata[15:0];
        n.m_nxt_pg = lnk.mem_rdata[`SGD_B_ENTRY_IRQ];
        n.m_nxt_full = 1'b1;
        // RULE1: step by one eight-byte entry
        // RULE22: list length drops by eight
        n.l_cur_addr = s.l_cur_addr + `SGD_ENTRY_STRIDE;
        n.l_cur_cnt = s.l_cur_cnt - `SGD_ENTRY_BYTES;
        n.fetch = SGD_F_IDLE;
      end
      default: n.fetch = SGD_F_IDLE;
    endcase

    // RULE20: list is done once every page has drained
    if (s.l_active && (s.l_cur_cnt == 16'h0000) && (s.fetch == SGD_F_IDLE)
      && !s.m_nxt_full && !s.m_active)
    begin
      n.l_active = 1'b0;
      n.l_done = 1'b1;
      // RULE21: list completion interrupt
      if (s.ctl.list_irq_en)
        n.dma_int = 1'b1;
    end
    // RULE15: take next list only when valid and idle
    if (s.l_nxt_valid && !s.l_active)
    begin
      n.l_cur_addr = s.l_nxt_addr;
      n.l_cur_cnt = s.l_nxt_cnt;
      n.l_active = 1'b1;
      n.l_nxt_valid = 1'b0;
      // RULE18: start reads one when copy is made
      n.l_start = 1'b1;
      n.l_done = 1'b0;
      // RULE21: next-available interrupt
      if (s.ctl.rdy_irq_en)
        n.dma_int = 1'b1;
    end

    // RULE19: abort overrides all engine activity
    if (abort_now)
    begin
      n.fetch = SGD_F_IDLE;
      n.m_active = 1'b0;
      n.m_nxt_full = 1'b0;
      n.l_active = 1'b0;
      n.l_nxt_valid = 1'b0;
      n.l_start = 1'b0;
      n.l_done = 1'b0;
      n.rsp_main = 1'b0;
    end

    // Read mux, data stands in the following cycle
    n.rdata = 32'h0000_0000;
    if (lnk.reg_rd)
    begin
      case (lnk.reg_addr)
        `SGD_MAIN_CUR_ADDR: n.rdata = s.m_cur_addr;
        `SGD_MAIN_NXT_ADDR: n.rdata = s.m_nxt_addr;
        // RULE13: main current high half mirrors list view
        `SGD_MAIN_CUR_CC: n.rdata = {ctl_hi(s), s.m_cur_cnt};
        // RULE14: main next high half mirrors list view
        `SGD_MAIN_NXT_CC: n.rdata = {ctl_hi(s), s.m_nxt_cnt};
        `SGD_LIST_CUR_ADDR: n.rdata = s.l_cur_addr;
        `SGD_LIST_NXT_ADDR: n.rdata = s.l_nxt_addr;
        `SGD_LIST_CUR_CC: n.rdata = {ctl_hi(s), s.l_cur_cnt};
        // RULE19: abort bit always reads zero
        `SGD_LIST_NXT_CC: n.rdata = {ctl_hi(s), s.l_nxt_cnt};
        `SGD_FLASH_ADDR: n.rdata = s.flash_addr;
        `SGD_FLASH_DATA: n.rdata = {24'h00_0000, s.flash_data};
        `SGD_IRQ_CFG: n.rdata = s.irq_cfg;
        `SGD_IRQ_STATUS:
        begin
          n.rdata[`SGD_B_DMA_INT] = s.dma_int;
          n.rdata[`SGD_B_PAGE_INT] = s.pg_int;
        end
        `SGD_USER_DATA: n.rdata = s.user_data;
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Start bit reads one out of reset: next registers free to write
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.fetch <= SGD_F_IDLE;
      s.l_start <= 1'b1;
    end
    else
      s <= n;
  end

  // RULE21: interrupt gated by the global enable
  assign lnk.irq = s.irq_cfg[`SGD_B_GLOBAL_IRQ_EN] && (s.dma_int || s.pg_int);
  assign lnk.reg_rdata = s.rdata;
  assign ui_out_valid = s.ui_out_valid;
  assign ui_out_data = s.ui_out_data;
  assign list_busy = s.l_active;

endmodule

//--- hw/sgd_host.sv
`include "sgd_regs.svh"

module sgd_host
  import sgd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  sgd_link_if.host lnk,
  input wire logic [8:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [31:0] cmd_rdata,
  output logic cmd_refused,
  output logic host_irq
);

  sgd_host_st_t s;
  sgd_host_st_t n;
  logic [31:0] mem [`SGD_MEM_WORDS];
  logic to_dev;
  logic is_next;
  logic is_start;
  logic refuse;

  assign to_dev = !cmd_addr[`SGD_HOST_MEM_BIT];
  assign is_next = (cmd_addr[7:0] == `SGD_LIST_NXT_ADDR)
    || (cmd_addr[7:0] == `SGD_LIST_NXT_CC);
  assign is_start = (cmd_addr[7:0] == `SGD_LIST_NXT_CC)
    && cmd_wdata[`SGD_B_START] && !cmd_wdata[`SGD_B_ABORT];

  // Driver-side checks on writes going to the card
  always_comb
  begin
    refuse = 1'b0;
    // RULE17: flash window reserved for the update utility
    if ((cmd_addr[7:0] == `SGD_FLASH_ADDR)
      || (cmd_addr[7:0] == `SGD_FLASH_DATA))
      refuse = 1'b1;
    // RULE8: reload only after start seen asserted; abort always passes
    if (is_next && !s.open
      && !((cmd_addr[7:0] == `SGD_LIST_NXT_CC)
      && cmd_wdata[`SGD_B_ABORT]))
      refuse = 1'b1;
    // RULE7: address must precede the starting count write
    if (is_start && !s.armed)
      refuse = 1'b1;
    // RULE1: list length a whole number of entries
    if (is_start && ((cmd_wdata[15:0] & `SGD_ENTRY_ALIGN_MASK) != 16'h0000))
      refuse = 1'b1;
  end

  // Register port passes through to the card; refused writes never reach it
  assign lnk.reg_addr = cmd_addr[7:0];
  assign lnk.reg_wdata = cmd_wdata;
  assign lnk.reg_wr = cmd_wr && to_dev && !refuse;
  assign lnk.reg_rd = cmd_rd && to_dev;
  assign cmd_refused = cmd_wr && to_dev && refuse;

  always_comb
  begin
    n = s;
    // Host memory answers the card one cycle after each request
    n.mem_rd = mem[lnk.mem_addr[7:2]];
    n.cmd_mem = mem[cmd_addr[7:2]];
    n.sel_mem = !to_dev;
    n.cc_rd = cmd_rd && to_dev && (cmd_addr[7:0] == `SGD_LIST_NXT_CC);
    // RULE8: a read showing start asserted reopens the next registers
    if (s.cc_rd && lnk.reg_rdata[`SGD_B_START])
      n.open = 1'b1;
    if (lnk.reg_wr && (cmd_addr[7:0] == `SGD_LIST_NXT_ADDR))
      n.armed = 1'b1;
    // RULE7: a start consumes the armed address
    if (lnk.reg_wr && is_start)
    begin
      n.armed = 1'b0;
      n.open = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.open <= 1'b1;
    end
    else
      s <= n;
  end

  // Memory array; a driver write in the same word and cycle wins
  always_ff @(posedge clk_sys)
  begin
    if (lnk.mem_req && lnk.mem_we)
      mem[lnk.mem_addr[7:2]] <= lnk.mem_wdata;
    if (cmd_wr && !to_dev)
      mem[cmd_addr[7:2]] <= cmd_wdata;
  end

  assign lnk.mem_rdata = s.mem_rd;
  assign cmd_rdata = s.sel_mem ? s.cmd_mem : lnk.reg_rdata;
  assign host_irq = lnk.irq;

endmodule

//--- verification/sgd_link_monitor.sv
`include "sgd_regs.svh"

module sgd_link_monitor
  import sgd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] hi_q;

  // Upper half of the last read word, so mirror pairs can be compared
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      hi_q <= 16'h0;
    else
      hi_q <= reg_rdata[31:16];
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Read data stands one cycle only; a stale word would mislead software
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data seen without a read");

  a_abort_reads_zero: assert property (
    reg_rd && reg_addr == `SGD_LIST_NXT_CC |=> !reg_rdata[`SGD_B_ABORT])
    else $error("abort bit read back as one");

  a_list_count_whole: assert property (
    reg_rd && reg_addr == `SGD_LIST_NXT_CC |=> reg_rdata[2:0] == 3'h0)
    else $error("list length not a whole number of entries");

  a_word_aligned: assert property (
    mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("memory request not word aligned");

  a_next_addr_rw: assert property (
    reg_wr && reg_addr == `SGD_LIST_NXT_ADDR
    ##1 reg_rd && reg_addr == `SGD_LIST_NXT_ADDR
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("list next address did not keep written value");

  a_cur_mirror: assert property (
    reg_rd && reg_addr == `SGD_MAIN_CUR_CC
    ##1 reg_rd && reg_addr == `SGD_LIST_CUR_CC
    |=> reg_rdata[31:16] == hi_q)
    else $error("main current control half differs from list");

  a_nxt_mirror: assert property (
    reg_rd && reg_addr == `SGD_MAIN_NXT_CC
    ##1 reg_rd && reg_addr == `SGD_LIST_NXT_CC
    |=> reg_rdata[31:16] == hi_q)
    else $error("main next control half differs from list");

  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0)
    else $error("unmapped offset returned data");
endmodule

//--- verification/tb.sv
module tb
  import sgd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys;
  logic rst_b;
  logic ui_ready;
  logic [31:0] ui_in_data;
  logic ui_out_valid;
  logic [31:0] ui_out_data;
  logic list_busy;
  logic [8:0] cmd_addr;
  logic [31:0] cmd_wdata;
  logic cmd_wr;
  logic cmd_rd;
  logic [31:0] cmd_rdata;
  logic cmd_refused;
  logic host_irq;
  logic [31:0] rv;
  logic rf;
  logic [31:0] got_q[$];
  logic [8:0] pg[5] = '{9'h180, 9'h184, 9'h188, 9'h1a0, 9'h1a4};
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;

  sgd_link_if lnk();

  sgd_device sgd_device_inst (.clk_sys, .rst_b, .lnk(lnk.dev), .ui_ready,
    .ui_in_data, .ui_out_valid, .ui_out_data, .list_busy);

  sgd_host sgd_host_inst (.clk_sys, .rst_b, .lnk(lnk.host), .cmd_addr,
    .cmd_wdata, .cmd_wr, .cmd_rd, .cmd_rdata, .cmd_refused, .host_irq);

  sgd_link_monitor sgd_link_monitor_inst (.clk_sys, .rst_b,
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata),
    .mem_req(lnk.mem_req), .mem_addr(lnk.mem_addr));

  // Free running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // User side source: a new word after every word written to memory
  always @(posedge clk_sys)
    if (lnk.mem_req === 1'b1 && lnk.mem_we === 1'b1)
      ui_in_data <= ui_in_data + 32'h1;

  // Collect words handed to the user side
  always @(posedge clk_sys)
    if (ui_out_valid === 1'b1)
      got_q.push_back(ui_out_data);

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      $display("BAD run length expected end seen hang");
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One strobe cycle; also picks up the answer to the previous read
  task automatic op(input logic r, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cmd_rd <= r;
    cmd_wr <= !r;
    cmd_addr <= a;
    cmd_wdata <= d;
    #1;
    rv = cmd_rdata;
    rf = cmd_refused;
  endtask

  task automatic idle();
    @(posedge clk_sys);
    cmd_rd <= 1'b0;
    cmd_wr <= 1'b0;
    #1;
    rv = cmd_rdata;
  endtask

  task automatic rd(input logic [8:0] a);
    op(1'b1, a, 32'h0);
    idle();
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    op(1'b0, a, d);
    idle();
  endtask

  // Start the list at 0x40 and poll until it is done and reloadable
  task automatic run(input logic [31:0] cc);
    wr(9'h014, 32'h0000_0040);
    wr(9'h01c, cc);
    // next list only once start reads back set
    repeat (300)
    begin
      rd(9'h01c);
      if (rv[30] === 1'b1 && rv[29] === 1'b1)
        break;
    end
    // A poll that runs out is a failure, not a silent pass
    chk("list finished", 32'h6000_0000, rv & 32'h6000_0000);
  endtask

  initial
  begin
    rst_b = 1'b0;
    ui_ready = 1'b1;
    ui_in_data = 32'hcafe_0000;
    cmd_addr = 9'h0;
    cmd_wdata = 32'h0;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Reset view, read-only and refused places
    rd(9'h01c);
    chk("start bit", 32'h2000_0000, rv & 32'h2000_0000);
    wr(9'h000, 32'hffff_ffff);
    wr(9'h004, 32'hffff_ffff);
    rd(9'h000);
    chk("main current address", 32'h0, rv);
    rd(9'h004);
    chk("main next address", 32'h0, rv);
    rd(9'h020);
    chk("unmapped", 32'h0, rv);
    wr(9'h080, 32'h1);
    chk("flash write dropped", 32'h1, {31'h0, rf});
    op(1'b0, 9'h014, 32'h0000_0040);
    op(1'b1, 9'h014, 32'h0);
    idle();
    chk("list next address", 32'h0000_0040, rv);
    wr(9'h01c, 32'h2000_000c);
    chk("partial entry start", 32'h1, {31'h0, rf});
    op(1'b1, 9'h008, 32'h0);
    op(1'b1, 9'h018, 32'h0);
    op(1'b1, 9'h00c, 32'h0);
    op(1'b1, 9'h01c, 32'h0);
    idle();
    $display("test registers done");
    // Two-page list, card writes memory, page and list interrupts on
    wr(9'h140, 32'h0000_0080);
    wr(9'h144, 32'h0001_0003);
    wr(9'h148, 32'h0000_00a0);
    wr(9'h14c, 32'h0000_0002);
    wr(9'h0c4, 32'h0000_8000);
    // Guard words just past each page must stay untouched
    wr(9'h18c, 32'h0);
    wr(9'h1a8, 32'h0);
    run(32'h3800_0010);
    for (int i = 0; i < 5; i++)
    begin
      rd(pg[i]);
      chk("page word", 32'hcafe_0000 + i, rv);
    end
    rd(9'h18c);
    chk("after first page", 32'h0, rv);
    rd(9'h1a8);
    chk("after second page", 32'h0, rv);
    rd(9'h0c8);
    chk("status", 32'h0004_1000, rv & 32'h0004_1000);
    chk("irq", 32'h1, {31'h0, host_irq});
    rd(9'h018);
    chk("list remaining", 32'h0, rv & 32'hffff);
    rd(9'h008);
    chk("page remaining", 32'h0, rv & 32'hffff);
    rd(9'h01c);
    chk("done bit", 32'h4000_0000, rv & 32'h4000_0000);
    wr(9'h0c4, 32'h0);
    chk("irq masked", 32'h0, {31'h0, host_irq});
    $display("test write list done");
    // Same list, card reads memory to the user side, no enables
    got_q.delete();
    run(32'h2200_0010);
    chk("words out", 32'h5, 32'(got_q.size()));
    for (int i = 0; i < 5; i++)
      chk("word out", 32'hcafe_0000 + i, got_q[i]);
    rd(9'h0c8);
    chk("status quiet", 32'h0, rv & 32'h0004_1000);
    $display("test read list done");
    // Abort while the user side stalls; ready interrupt and burst set
    @(posedge clk_sys);
    ui_ready <= 1'b0;
    wr(9'h014, 32'h0000_0040);
    wr(9'h01c, 32'ha100_0010);
    wr(9'h014, 32'h0000_0100);
    chk("reload before start seen", 32'h1, {31'h0, rf});
    rd(9'h01c);
    chk("done while running", 32'h0, rv & 32'h4000_0000);
    chk("burst kept", 32'h0100_0000, rv & 32'h0100_0000);
    chk("busy", 32'h1, {31'h0, list_busy});
    rd(9'h0c8);
    chk("ready int", 32'h0000_1000, rv & 32'h0000_1000);
    // Let both entries reach the main registers
    repeat (10) idle();
    rd(9'h000);
    chk("stalled current address", 32'h0000_0080, rv);
    rd(9'h004);
    chk("queued next address", 32'h0000_00a0, rv);
    rd(9'h008);
    chk("stalled count", 32'h3, rv & 32'hffff);
    rd(9'h00c);
    chk("queued count", 32'h2, rv & 32'hffff);
    wr(9'h01c, 32'h0400_0000);
    rd(9'h01c);
    chk("after abort", 32'h0, rv & 32'h6400_0000);
    chk("main idle empty", 32'h00c0_0000, rv & 32'h00c0_0000);
    chk("busy after abort", 32'h0, {31'h0, list_busy});
    rd(9'h180);
    chk("page untouched", 32'hcafe_0000, rv);
    wr(9'h01c, 32'h2000_0010);
    chk("start without address", 32'h1, {31'h0, rf});
    $display("test abort done");
    give_verdict();
  end
endmodule
